// file: hdl/acs_pkg.sv
// Shared constants, types and helpers for the converter conversion sequencer
package acs_pkg;

    // Clock and timing
    localparam int CLK_FREQ_MHZ = 25;
    localparam int AUTO_BASE_US = 1000;
    localparam int POWEROFF_DLY_US = 1000;
    localparam int CNT_W = 32;

    // Field widths
    localparam int RESULT_W = 12;
    localparam int CHAN_W = 4;
    localparam int ISRC_W = 2;
    localparam int RATE_W = 3;
    localparam int REG_W = 8;
    localparam int FLAG_W = 4;

    // Status flag positions in the group-3 flag and mask vectors
    localparam int FLAG_SOFT0 = 0;
    localparam int FLAG_SOFT1 = 1;
    localparam int FLAG_AUTO0 = 2;
    localparam int FLAG_AUTO1 = 3;

    // Result and limit register layout
    localparam int RES_HI_MSB = 11;
    localparam int RES_HI_LSB = 8;
    localparam int RES_LO_MSB = 7;
    localparam int LIMIT_HI_MSB = 3;
    localparam int LIMIT_POL_BIT = 7;
    localparam logic [3:0] RES_HI_PAD = 4'h0;

    // Current source channel, source-off value, reset values and counter step
    localparam logic [CHAN_W-1:0] CHAN_ZERO = 4'h0;
    localparam logic [ISRC_W-1:0] ISRC_OFF = 2'h0;
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;

    typedef enum logic [1:0] {ACS_IDLE, ACS_START, ACS_WAIT} acs_state_t;

    // Upper result register: four data bits, upper bits read zero
    function automatic logic [REG_W-1:0] result_high(input logic [RESULT_W-1:0] r);
        result_high = {RES_HI_PAD, r[RES_HI_MSB:RES_HI_LSB]};
    endfunction

    function automatic logic [REG_W-1:0] result_low(input logic [RESULT_W-1:0] r);
        result_low = r[RES_LO_MSB:0];
    endfunction

    // Twelve-bit threshold from its register pair
    function automatic logic [RESULT_W-1:0] limit_value(input logic [REG_W-1:0] hi,
                                                        input logic [REG_W-1:0] lo);
        limit_value = {hi[LIMIT_HI_MSB:0], lo};
    endfunction

    // Automatic period doubles with each step of the rate field
    function automatic logic [CNT_W-1:0] rate_period(input logic [CNT_W-1:0] base,
                                                     input logic [RATE_W-1:0] field);
        rate_period = base << field;
    endfunction

endpackage

// file: hdl/acs_rate_timer.sv
// Periodic tick generator for automatic conversions
`timescale 1ns/10ps
module acs_rate_timer
    import acs_pkg::*;
#(
    parameter int BASE_CYCLES = AUTO_BASE_US * CLK_FREQ_MHZ
)
(
    input wire logic clk_in, // System clock
    input wire logic rst_in, // Synchronous reset
    input wire logic run_in, // Any automatic slot enabled
    input wire logic [RATE_W-1:0] rate_in, // Rate field
    output logic tick_out // One-cycle conversion request
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] period;

    assign period = rate_period(CNT_W'(BASE_CYCLES), rate_in);

    always_ff @(posedge clk_in)
    begin
        if (rst_in || !run_in)
        begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end
        else if (cnt_q >= period - CNT_ONE)
        begin
            cnt_q <= '0;
            tick_out <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + CNT_ONE;
            tick_out <= 1'b0;
        end
    end

endmodule

// file: hdl/acs_limit_compare.sv
// Threshold comparison with selectable polarity
`timescale 1ns/10ps
module acs_limit_compare
    import acs_pkg::*;
(
    input wire logic [RESULT_W-1:0] result_in, // Conversion result
    input wire logic [REG_W-1:0] limit_high_in, // Limit high register with polarity
    input wire logic [REG_W-1:0] limit_low_in, // Limit low register
    output logic cross_out // Result beyond limit
);

    logic [RESULT_W-1:0] limit;

    assign limit = limit_value(limit_high_in, limit_low_in);
    // Polarity set flags above, clear flags below
    assign cross_out = limit_high_in[LIMIT_POL_BIT] ? (result_in > limit)
                                                    : (result_in < limit);
endmodule

// file: hdl/acs_sequencer.sv
// Conversion sequencer for the general-purpose converter
`timescale 1ns/10ps
// Summary of operation
// - Software starts are honoured only while software conversion is enabled.
// - A software conversion uses the channel chosen for its slot.
// - Channel zero gets the programmed current source setting.
// - Converter powered only during conversions unless force-on is set.
// - Software done interrupt raised only when its mask bit is clear.
// - Start bit begins a conversion; completion sets software done flag.
// - Twelve-bit result split: high bits [3:0], low bits [7:0].
// - Automatic conversions repeat on the slot channel at the programmed rate.
// - Automatic results are compared against a twelve-bit threshold pair.
// - Polarity bit picks flagging above or below the threshold.
// - Enabled automatic slot sets its flag and interrupt on threshold crossing.
// - Automatic results go to their own register pair per slot.
// - With poweroff enabled, a crossing starts a delay that ends in power off if its flag stays set throughout.
// - Slot one behaves like slot zero, except that slot zero is converted first when both are due.
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int AUTO_BASE_CYCLES = AUTO_BASE_US * CLK_FREQ_MHZ,
    parameter int POWEROFF_DLY_CYCLES = POWEROFF_DLY_US * CLK_FREQ_MHZ
)
(
    input wire logic clk_in, // 25 MHz clock
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic soft_conv_enable_in, // Software conversion mode
    input wire logic [CHAN_W-1:0] soft_slot0_channel_in, // Software slot 0 channel
    input wire logic [CHAN_W-1:0] soft_slot1_channel_in, // Software slot 1 channel
    input wire logic soft_slot0_start_in, // Start pulse, slot 0
    input wire logic soft_slot1_start_in, // Start pulse, slot 1
    input wire logic [ISRC_W-1:0] current_source_in, // Channel 0 current source
    input wire logic converter_force_on_in, // Keep converter powered
    input wire logic [FLAG_W-1:0] irq_group3_mask_in, // Interrupt masks, 1 masks
    input wire logic [FLAG_W-1:0] irq_group3_clear_in, // Flag clear pulses
    input wire logic [CHAN_W-1:0] auto_slot0_channel_in, // Automatic slot 0 channel
    input wire logic [CHAN_W-1:0] auto_slot1_channel_in, // Automatic slot 1 channel
    input wire logic [RATE_W-1:0] auto_rate_field_in, // Automatic rate
    input wire logic auto_slot0_enable_in, // Automatic slot 0 enable
    input wire logic auto_slot1_enable_in, // Automatic slot 1 enable
    input wire logic [REG_W-1:0] slot0_limit_high_in, // Slot 0 limit high and polarity
    input wire logic [REG_W-1:0] slot0_limit_low_in, // Slot 0 limit low
    input wire logic [REG_W-1:0] slot1_limit_high_in, // Slot 1 limit high and polarity
    input wire logic [REG_W-1:0] slot1_limit_low_in, // Slot 1 limit low
    input wire logic slot0_poweroff_enable_in, // Slot 0 shutdown enable
    input wire logic slot1_poweroff_enable_in, // Slot 1 shutdown enable
    input wire logic adc_done_in, // Converter finished, one cycle
    input wire logic [RESULT_W-1:0] adc_data_in, // Converter result
    output logic adc_power_out, // Converter power
    output logic adc_start_out, // Converter start pulse
    output logic [CHAN_W-1:0] adc_channel_out, // Channel under conversion
    output logic [ISRC_W-1:0] adc_isource_out, // Current source setting
    output logic [FLAG_W-1:0] irq_group3_flags_out, // Sticky status flags
    output logic irq_out, // Interrupt, active high
    output logic [REG_W-1:0] soft_result0_high_out, // Software slot 0 result high
    output logic [REG_W-1:0] soft_result0_low_out, // Software slot 0 result low
    output logic [REG_W-1:0] soft_result1_high_out, // Software slot 1 result high
    output logic [REG_W-1:0] soft_result1_low_out, // Software slot 1 result low
    output logic [REG_W-1:0] auto_result0_high_out, // Automatic slot 0 result high
    output logic [REG_W-1:0] auto_result0_low_out, // Automatic slot 0 result low
    output logic [REG_W-1:0] auto_result1_high_out, // Automatic slot 1 result high
    output logic [REG_W-1:0] auto_result1_low_out, // Automatic slot 1 result low
    output logic poweroff_out // Chip switch-off request
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    acs_state_t state_q;
    logic [FLAG_W-1:0] pend_q;
    logic [FLAG_W-1:0] pend_set;
    logic [1:0] src_q;
    logic [1:0] src_pick;
    logic [CHAN_W-1:0] chan_q;
    logic [CHAN_W-1:0] chan_pick;
    logic [FLAG_W-1:0] flags_q;
    logic [FLAG_W-1:0] flags_set;
    logic [RESULT_W-1:0] soft0_q;
    logic [RESULT_W-1:0] soft1_q;
    logic [RESULT_W-1:0] auto0_q;
    logic [RESULT_W-1:0] auto1_q;
    logic [1:0] armed_q;
    logic [CNT_W-1:0] dly_q;
    logic poweroff_q;
    logic auto_tick;
    logic cross0;
    logic cross1;
    logic done;

    ////////////////////////////////////////////////////////////////////////////
    // Automatic rate and threshold checks

    acs_rate_timer #(
        .BASE_CYCLES(AUTO_BASE_CYCLES)
    ) u_rate (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(auto_slot0_enable_in || auto_slot1_enable_in),
        .rate_in(auto_rate_field_in),
        .tick_out(auto_tick)
    );

    acs_limit_compare u_cmp0 (
        .result_in(adc_data_in),
        .limit_high_in(slot0_limit_high_in),
        .limit_low_in(slot0_limit_low_in),
        .cross_out(cross0)
    );

    acs_limit_compare u_cmp1 (
        .result_in(adc_data_in),
        .limit_high_in(slot1_limit_high_in),
        .limit_low_in(slot1_limit_low_in),
        .cross_out(cross1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request collection

    always_comb
    begin
        pend_set = '0;
        pend_set[FLAG_SOFT0] = soft_slot0_start_in && soft_conv_enable_in;
        pend_set[FLAG_SOFT1] = soft_slot1_start_in && soft_conv_enable_in;
        pend_set[FLAG_AUTO0] = auto_tick && auto_slot0_enable_in;
        pend_set[FLAG_AUTO1] = auto_tick && auto_slot1_enable_in;
    end

    // Fixed priority: software slots first, then automatic
    always_comb
    begin
        src_pick = 2'(FLAG_AUTO1);
        chan_pick = auto_slot1_channel_in;
        if (pend_q[FLAG_SOFT0])
        begin
            src_pick = 2'(FLAG_SOFT0);
            chan_pick = soft_slot0_channel_in;
        end
        else if (pend_q[FLAG_SOFT1])
        begin
            src_pick = 2'(FLAG_SOFT1);
            chan_pick = soft_slot1_channel_in;
        end
        else if (pend_q[FLAG_AUTO0])
        begin
            src_pick = 2'(FLAG_AUTO0);
            chan_pick = auto_slot0_channel_in;
        end
    end

    assign done = (state_q == ACS_WAIT) && adc_done_in;

    // New request wins over the pick that consumes it
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pend_q <= '0;
        end
        else if (state_q == ACS_IDLE && pend_q != '0)
        begin
            pend_q <= (pend_q & ~(FLAG_W'(1) << src_pick)) | pend_set;
        end
        else
        begin
            pend_q <= pend_q | pend_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion state machine

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_q <= ACS_IDLE;
            src_q <= '0;
            chan_q <= CHAN_ZERO;
        end
        else
        begin
            case (state_q)
                ACS_IDLE:
                begin
                    if (pend_q != '0)
                    begin
                        src_q <= src_pick;
                        chan_q <= chan_pick;
                        state_q <= ACS_START;
                    end
                end
                ACS_START:
                begin
                    state_q <= ACS_WAIT;
                end
                ACS_WAIT:
                begin
                    if (adc_done_in)
                    begin
                        state_q <= ACS_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ACS_IDLE;
                end
            endcase
        end
    end

    assign adc_start_out = (state_q == ACS_START);
    assign adc_channel_out = chan_q;
    assign adc_power_out = converter_force_on_in || (state_q != ACS_IDLE);
    assign adc_isource_out = (state_q != ACS_IDLE && chan_q == CHAN_ZERO)
                             ? current_source_in : ISRC_OFF;

    ////////////////////////////////////////////////////////////////////////////
    // Result registers, whole word loaded at once

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            soft0_q <= RESULT_RST;
            soft1_q <= RESULT_RST;
            auto0_q <= RESULT_RST;
            auto1_q <= RESULT_RST;
        end
        else if (done)
        begin
            if (src_q == 2'(FLAG_SOFT0))
            begin
                soft0_q <= adc_data_in;
            end
            if (src_q == 2'(FLAG_SOFT1))
            begin
                soft1_q <= adc_data_in;
            end
            if (src_q == 2'(FLAG_AUTO0))
            begin
                auto0_q <= adc_data_in;
            end
            if (src_q == 2'(FLAG_AUTO1))
            begin
                auto1_q <= adc_data_in;
            end
        end
    end

    assign soft_result0_high_out = result_high(soft0_q);
    assign soft_result0_low_out = result_low(soft0_q);
    assign soft_result1_high_out = result_high(soft1_q);
    assign soft_result1_low_out = result_low(soft1_q);
    assign auto_result0_high_out = result_high(auto0_q);
    assign auto_result0_low_out = result_low(auto0_q);
    assign auto_result1_high_out = result_high(auto1_q);
    assign auto_result1_low_out = result_low(auto1_q);

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and interrupt

    always_comb
    begin
        flags_set = '0;
        flags_set[FLAG_SOFT0] = done && src_q == 2'(FLAG_SOFT0);
        flags_set[FLAG_SOFT1] = done && src_q == 2'(FLAG_SOFT1);
        flags_set[FLAG_AUTO0] = done && src_q == 2'(FLAG_AUTO0) && cross0;
        flags_set[FLAG_AUTO1] = done && src_q == 2'(FLAG_AUTO1) && cross1;
    end

    // Set beats a clear landing in the same cycle
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            flags_q <= FLAGS_RST;
        end
        else
        begin
            flags_q <= (flags_q & ~irq_group3_clear_in) | flags_set;
        end
    end

    assign irq_group3_flags_out = flags_q;
    assign irq_out = |(flags_q & ~irq_group3_mask_in);

    ////////////////////////////////////////////////////////////////////////////
    // Switch-off delay

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            armed_q <= '0;
        end
        else
        begin
            armed_q[0] <= (armed_q[0] && flags_q[FLAG_AUTO0]
                          && !irq_group3_clear_in[FLAG_AUTO0])
                          || (flags_set[FLAG_AUTO0] && slot0_poweroff_enable_in);
            armed_q[1] <= (armed_q[1] && flags_q[FLAG_AUTO1]
                          && !irq_group3_clear_in[FLAG_AUTO1])
                          || (flags_set[FLAG_AUTO1] && slot1_poweroff_enable_in);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in || armed_q == '0)
        begin
            dly_q <= '0;
        end
        else if (dly_q < CNT_W'(POWEROFF_DLY_CYCLES))
        begin
            dly_q <= dly_q + CNT_ONE;
        end
    end

    // Latched until reset once the delay runs out
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            poweroff_q <= 1'b0;
        end
        else if (armed_q != '0 && dly_q >= CNT_W'(POWEROFF_DLY_CYCLES) - CNT_ONE)
        begin
            poweroff_q <= 1'b1;
        end
    end

    assign poweroff_out = poweroff_q;

endmodule

// file: verification/acs_sequencer_sva.sv
// Port-level assertions for the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_sva
    import acs_pkg::*;
(
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Sync reset
    input wire logic converter_force_on_in, // Force on
    input wire logic [ISRC_W-1:0] current_source_in, // Current source
    input wire logic [FLAG_W-1:0] irq_group3_mask_in, // Masks
    input wire logic [FLAG_W-1:0] irq_group3_clear_in, // Clears
    input wire logic adc_done_in, // Converter done
    input wire logic [RESULT_W-1:0] adc_data_in, // Converter data
    input wire logic adc_power_out, // Converter power
    input wire logic adc_start_out, // Converter start
    input wire logic [CHAN_W-1:0] adc_channel_out, // Channel
    input wire logic [ISRC_W-1:0] adc_isource_out, // Current source out
    input wire logic [FLAG_W-1:0] irq_group3_flags_out, // Flags
    input wire logic irq_out, // Interrupt
    input wire logic [REG_W-1:0] soft_result0_high_out, // Result high
    input wire logic [REG_W-1:0] soft_result0_low_out, // Result low
    input wire logic poweroff_out // Switch-off
);
    logic [FLAG_W-1:0] keep_q;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Flags that must survive the next edge
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            keep_q <= FLAGS_RST;
        else
            keep_q <= irq_group3_flags_out & ~irq_group3_clear_in;
    end

    ////////////////////////////////////////////////////////////////
    AST_START_ONE: assert property (adc_start_out |=> !adc_start_out)
        else $error("start pulse longer than one cycle");
    AST_POWER_BUSY: assert property (adc_start_out |-> adc_power_out ##1 adc_power_out)
        else $error("converter unpowered during conversion");
    AST_FORCE_ON: assert property (converter_force_on_in |-> adc_power_out)
        else $error("force-on ignored");
    AST_ISRC_CH0: assert property (adc_start_out && adc_channel_out == CHAN_ZERO
        |-> adc_isource_out == current_source_in) else $error("current source missing");
    AST_ISRC_OTHER: assert property (adc_start_out && adc_channel_out != CHAN_ZERO
        |-> adc_isource_out == ISRC_OFF) else $error("current source on wrong channel");
    AST_IRQ_MASK: assert property (irq_out == |(irq_group3_flags_out & ~irq_group3_mask_in))
        else $error("interrupt disagrees with flags and mask");
    AST_FLAG_HOLD: assert property ((irq_group3_flags_out & keep_q) == keep_q)
        else $error("flag dropped without clear");
    AST_FLAG_CAUSE: assert property ((irq_group3_flags_out & ~$past(irq_group3_flags_out))
        != FLAGS_RST |-> $past(adc_done_in)) else $error("flag set without conversion");
    AST_RESULT_PAIR: assert property ($changed(soft_result0_low_out)
        || $changed(soft_result0_high_out) |-> {soft_result0_high_out, soft_result0_low_out}
        == {4'h0, $past(adc_data_in)}) else $error("result pair mismatch");
    AST_OFF_HOLD: assert property (poweroff_out |=> poweroff_out)
        else $error("switch-off request dropped");
    AST_OFF_CAUSE: assert property ($rose(poweroff_out) |-> $past(irq_group3_flags_out)
        != FLAGS_RST) else $error("switch-off without pending flag");

    COV_SOFT: cover property ($rose(irq_group3_flags_out[FLAG_SOFT0]));
    COV_AUTO: cover property ($rose(irq_group3_flags_out[FLAG_AUTO1]));
    COV_OFF: cover property ($rose(poweroff_out));
endmodule

bind acs_sequencer acs_sequencer_sva i_sva (.clk_in, .rst_in, .converter_force_on_in,
    .current_source_in, .irq_group3_mask_in, .irq_group3_clear_in, .adc_done_in, .adc_data_in,
    .adc_power_out, .adc_start_out, .adc_channel_out, .adc_isource_out, .irq_group3_flags_out,
    .irq_out, .soft_result0_high_out, .soft_result0_low_out, .poweroff_out);

// file: verification/tb_acs_sequencer.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_acs_sequencer
    import acs_pkg::*;
;
    localparam int DLY = 10;
    localparam int BASE = 8;
    logic clk_in, rst_in, soft_conv_enable_in, soft_slot0_start_in, soft_slot1_start_in;
    logic converter_force_on_in, auto_slot0_enable_in, auto_slot1_enable_in, adc_done_in;
    logic slot0_poweroff_enable_in, slot1_poweroff_enable_in;
    logic adc_power_out, adc_start_out, irq_out, poweroff_out;
    logic [CHAN_W-1:0] soft_slot0_channel_in, soft_slot1_channel_in, adc_channel_out;
    logic [CHAN_W-1:0] auto_slot0_channel_in, auto_slot1_channel_in;
    logic [ISRC_W-1:0] current_source_in, adc_isource_out;
    logic [FLAG_W-1:0] irq_group3_mask_in, irq_group3_clear_in, irq_group3_flags_out;
    logic [RATE_W-1:0] auto_rate_field_in;
    logic [REG_W-1:0] slot0_limit_high_in, slot0_limit_low_in;
    logic [REG_W-1:0] slot1_limit_high_in, slot1_limit_low_in;
    logic [REG_W-1:0] soft_result0_high_out, soft_result0_low_out;
    logic [REG_W-1:0] soft_result1_high_out, soft_result1_low_out;
    logic [REG_W-1:0] auto_result0_high_out, auto_result0_low_out;
    logic [REG_W-1:0] auto_result1_high_out, auto_result1_low_out;
    logic [RESULT_W-1:0] adc_data_in, adc_val;
    int fails = 0;
    int n_compared = 0;
    int cnt = 0;

    acs_sequencer #(.AUTO_BASE_CYCLES(BASE), .POWEROFF_DLY_CYCLES(DLY)) i_dut (.clk_in, .rst_in,
        .soft_conv_enable_in, .soft_slot0_channel_in, .soft_slot1_channel_in,
        .soft_slot0_start_in, .soft_slot1_start_in, .current_source_in, .converter_force_on_in,
        .irq_group3_mask_in, .irq_group3_clear_in, .auto_slot0_channel_in,
        .auto_slot1_channel_in, .auto_rate_field_in, .auto_slot0_enable_in,
        .auto_slot1_enable_in, .slot0_limit_high_in, .slot0_limit_low_in, .slot1_limit_high_in,
        .slot1_limit_low_in, .slot0_poweroff_enable_in, .slot1_poweroff_enable_in,
        .adc_done_in, .adc_data_in, .adc_power_out, .adc_start_out, .adc_channel_out,
        .adc_isource_out, .irq_group3_flags_out, .irq_out, .soft_result0_high_out,
        .soft_result0_low_out, .soft_result1_high_out, .soft_result1_low_out,
        .auto_result0_high_out, .auto_result0_low_out, .auto_result1_high_out,
        .auto_result1_low_out, .poweroff_out);

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // Converter stand-in: done three cycles after start, data garbled otherwise
    always @(negedge clk_in)
    begin
        adc_done_in <= (cnt == 1);
        adc_data_in <= (cnt == 1) ? adc_val : ~adc_val;
        cnt = adc_start_out ? 3 : (cnt > 0 ? cnt - 1 : 0);
    end

    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic clear(logic [FLAG_W-1:0] m);
        irq_group3_clear_in = m;
        tick(1);
        irq_group3_clear_in = 4'h0;
        tick(1);
    endtask

    task automatic wait_done();
        int k;
        k = 0;
        while (adc_done_in !== 1'b1 && k < 100)
        begin
            @(posedge clk_in);
            k++;
        end
        `CHK(adc_done_in, 1'b1)
        tick(1);
    endtask

    task automatic soft_conv(int s, logic [CHAN_W-1:0] ch, logic [RESULT_W-1:0] d);
        int k;
        logic [15:0] got;
        adc_val = d;
        soft_slot0_channel_in = (s == 0) ? ch : ~ch;
        soft_slot1_channel_in = (s == 1) ? ch : ~ch;
        soft_slot0_start_in = (s == 0);
        soft_slot1_start_in = (s == 1);
        tick(1);
        soft_slot0_start_in = 1'b0;
        soft_slot1_start_in = 1'b0;
        k = 0;
        while (adc_start_out !== 1'b1 && k < 8)
        begin
            tick(1);
            k++;
        end
        `CHK(adc_channel_out, ch)
        `CHK(adc_isource_out, ch == CHAN_ZERO ? current_source_in : ISRC_OFF)
        wait_done();
        `CHK(irq_group3_flags_out[FLAG_SOFT0 + s], 1'b1)
        got = s ? {soft_result1_high_out, soft_result1_low_out}
                : {soft_result0_high_out, soft_result0_low_out};
        `CHK(got, {4'h0, d})
    endtask

    task automatic auto_case(int s, logic pol, logic [RESULT_W-1:0] lim, logic [RESULT_W-1:0] d);
        logic [15:0] got;
        logic hit;
        int k;
        hit = pol ? (d > lim) : (d < lim);
        adc_val = d;
        slot0_limit_high_in = {pol ^ (s == 1), 3'h0, lim[11:8]};
        slot1_limit_high_in = {pol ^ (s == 0), 3'h0, lim[11:8]};
        slot0_limit_low_in = lim[7:0];
        slot1_limit_low_in = lim[7:0];
        auto_slot0_enable_in = (s == 0);
        auto_slot1_enable_in = (s == 1);
        k = 0;
        while (adc_start_out !== 1'b1 && k < 100)
        begin
            tick(1);
            k++;
        end
        `CHK(k, (BASE << auto_rate_field_in) + 2)
        wait_done();
        auto_slot0_enable_in = 1'b0;
        auto_slot1_enable_in = 1'b0;
        `CHK(adc_channel_out, s ? auto_slot1_channel_in : auto_slot0_channel_in)
        got = s ? {auto_result1_high_out, auto_result1_low_out}
                : {auto_result0_high_out, auto_result0_low_out};
        `CHK(got, {4'h0, d})
        `CHK(irq_group3_flags_out[FLAG_AUTO0 + s], hit)
        `CHK(irq_out, hit)
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        {soft_conv_enable_in, soft_slot0_start_in, soft_slot1_start_in, converter_force_on_in,
            auto_slot0_enable_in, auto_slot1_enable_in, slot0_poweroff_enable_in,
            slot1_poweroff_enable_in} = 8'h00;
        {soft_slot0_channel_in, soft_slot1_channel_in, current_source_in, irq_group3_mask_in,
            irq_group3_clear_in, auto_rate_field_in, slot0_limit_high_in, slot0_limit_low_in,
            slot1_limit_high_in, slot1_limit_low_in} = 53'h0;
        adc_val = 12'h000;
        auto_slot0_channel_in = 4'h6;
        auto_slot1_channel_in = 4'h9;
        rst_in = 1'b1;
        tick(8);
        rst_in = 1'b0;
        `CHK(irq_group3_flags_out, FLAGS_RST)
        `CHK(adc_power_out, 1'b0)
        converter_force_on_in = 1'b1;
        tick(1);
        `CHK(adc_power_out, 1'b1)
        converter_force_on_in = 1'b0;
        soft_slot0_start_in = 1'b1;
        tick(1);
        soft_slot0_start_in = 1'b0;
        tick(8);
        `CHK(irq_group3_flags_out, FLAGS_RST)
        $display("reset, power and disabled start test done");
        soft_conv_enable_in = 1'b1;
        current_source_in = 2'h2;
        irq_group3_mask_in = 4'hF;
        soft_conv(0, 4'h0, 12'hA5C);
        `CHK(irq_out, 1'b0)
        irq_group3_mask_in = 4'hE;
        tick(1);
        `CHK(irq_out, 1'b1)
        soft_conv(1, 4'h5, 12'h3F1);
        `CHK(irq_group3_flags_out[FLAG_SOFT0], 1'b1)
        clear(4'h3);
        `CHK(irq_group3_flags_out, FLAGS_RST)
        $display("software conversion test done");
        irq_group3_mask_in = 4'h0;
        auto_case(0, 1'b1, 12'h800, 12'h900);
        clear(4'hC);
        tick(12);
        auto_case(0, 1'b1, 12'h800, 12'h800);
        tick(12);
        auto_case(0, 1'b0, 12'h800, 12'h7FF);
        clear(4'hC);
        tick(12);
        auto_rate_field_in = 3'h1;
        auto_case(1, 1'b0, 12'h800, 12'h900);
        tick(12);
        auto_case(1, 1'b1, 12'h0FF, 12'h100);
        clear(4'hC);
        tick(12);
        $display("automatic conversion test done");
        slot0_poweroff_enable_in = 1'b1;
        auto_case(0, 1'b1, 12'h100, 12'h200);
        tick(2);
        clear(4'hC);
        tick(DLY + 5);
        `CHK(poweroff_out, 1'b0)
        auto_case(0, 1'b1, 12'h100, 12'h200);
        tick(DLY - 2);
        `CHK(poweroff_out, 1'b0)
        tick(2);
        `CHK(poweroff_out, 1'b1)
        $display("switch-off test done");
        end_sim();
    end

    initial
    begin
        repeat (5000) @(posedge clk_in);
        fails++;
        $display("watchdog expired");
        end_sim();
    end
endmodule
